// ### logic/internal_osc_clock_select.sv
/*
  internal oscillator block and system clock selection with an
  AXI4-Lite register slave.
  assumes configuration straps and the external clock pin arrive
  asynchronously; GPIO port logic for the output pin is on aclk.
*/
`timescale 1ns/1ns
module internal_osc_clock_select
  import osc_clk_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cfg_osc_select,
  input wire logic cfg_clock_output_pin_enable,
  input wire logic external_clock_input_pin,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic sys_clk_tick,
  output logic instr_clk,
  output logic internal_osc_mode,
  output logic external_clock_input_pin_released,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe
);

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  logic [3:0] sync_a_r;
  logic [3:0] sync_b_r;
  logic ext_d_r;
  logic [1:0] cfg_osc_sel;
  logic cfg_clock_output_pin_en;
  logic ext_lvl;
  logic ext_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_r <= 4'h0;
      sync_b_r <= 4'h0;
      ext_d_r <= 1'b0;
    end else begin
      sync_a_r <= {external_clock_input_pin, cfg_clock_output_pin_enable, cfg_osc_select};
      sync_b_r <= sync_a_r;
      ext_d_r <= sync_b_r[3];
    end
  end

  assign cfg_osc_sel = sync_b_r[1:0];
  assign cfg_clock_output_pin_en = sync_b_r[2];
  assign ext_lvl = sync_b_r[3];
  assign ext_tick = ext_lvl & !ext_d_r;

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  osc_ctrl_t ctrl_r;
  logic [TRIM_W-1:0] trim_r;
  osc_status_t status;

  // -------------------------------------------------------------
  // write channel
  // -------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_fire;
  logic w_fire;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic aw_got_nxt;
  logic w_got_nxt;
  logic bvalid_nxt;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ctrl;
  logic wr_trim;
  logic wr_mapped;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign aw_have = aw_got_r | aw_fire;
  assign w_have = w_got_r | w_fire;
  assign do_write = aw_have & w_have & !s_axi_bvalid;
  assign aw_got_nxt = aw_have & !do_write;
  assign w_got_nxt = w_have & !do_write;
  assign bvalid_nxt = do_write | (s_axi_bvalid & !s_axi_bready);
  assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
  assign wr_ctrl = do_write & (wr_addr == ADDR_W'(CTRL_OFS)) & wr_strb[0];
  assign wr_trim = do_write & (wr_addr == ADDR_W'(TRIM_OFS)) & wr_strb[0];
  assign wr_mapped = (wr_addr == ADDR_W'(CTRL_OFS)) | (wr_addr == ADDR_W'(TRIM_OFS))
                   | (wr_addr == ADDR_W'(STAT_OFS));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_fire) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_got_nxt & !bvalid_nxt;
      s_axi_wready <= !w_got_nxt & !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // control and trim registers: run-time source select, frequency select and trim
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      trim_r <= TRIM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= osc_ctrl_t'({wr_data[6:3], 1'b0, wr_data[1:0]});
      end
      if (wr_trim) begin
        trim_r <= wr_data[TRIM_W-1:0];
      end
    end
  end

  // -------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------
  logic ar_fire;
  logic rvalid_nxt;
  logic [31:0] rd_data;
  logic rd_mapped;

  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rvalid_nxt = ar_fire | (s_axi_rvalid & !s_axi_rready);
  assign rd_mapped = (s_axi_araddr == ADDR_W'(CTRL_OFS)) | (s_axi_araddr == ADDR_W'(TRIM_OFS))
                   | (s_axi_araddr == ADDR_W'(STAT_OFS));
  assign rd_data = (s_axi_araddr == ADDR_W'(CTRL_OFS)) ? 32'(ctrl_r)
                 : (s_axi_araddr == ADDR_W'(STAT_OFS)) ? 32'(status)
                 : (s_axi_araddr == ADDR_W'(TRIM_OFS)) ? 32'(trim_r)
                 : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_fire) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // -------------------------------------------------------------
  // source enables
  // -------------------------------------------------------------
  logic int_mode;
  clk_src_t sel_src;
  logic hf_en;
  logic mf_en;
  logic lf_en;
  logic fsu_en;

  assign int_mode = (cfg_osc_sel == CFG_INTERNAL_OSC_MODE) | ctrl_r.sys_clk_source_select[1];
  assign sel_src = freq_src(ctrl_r.internal_freq_select);
  assign hf_en = int_mode & (sel_src == SRC_HF);
  assign mf_en = int_mode & ((sel_src == SRC_MF) | hf_en);
  assign lf_en = int_mode & (sel_src == SRC_LF);
  assign fsu_en = hf_en;

  // -------------------------------------------------------------
  // oscillators
  // -------------------------------------------------------------
  logic lf_tick;
  logic mf_tick;
  logic hf_tick;
  logic fsu_tick;
  logic lf_ready;
  logic mf_ready;
  logic hf_ready;
  logic hf_locked;
  logic hf_stable;
  logic fsu_ready;

  osc_source #(
    .INC(freq_to_inc(LF_HZ)),
    .START_CYC(LF_START_CYC),
    .LOCK_CYC(LF_START_CYC),
    .STABLE_CYC(LF_START_CYC)
  ) u_low_freq_internal_source (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(lf_en),
    .trim(TRIM_RST),
    .tick(lf_tick),
    .ready(lf_ready),
    .locked(),
    .stable()
  );

  osc_source #(
    .INC(freq_to_inc(MF_HZ)),
    .START_CYC(MF_START_CYC),
    .LOCK_CYC(MF_START_CYC),
    .STABLE_CYC(MF_START_CYC)
  ) u_mid_freq_internal_source (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(mf_en),
    .trim(trim_r),
    .tick(mf_tick),
    .ready(mf_ready),
    .locked(),
    .stable()
  );

  // multiplier loop only runs once its reference is up
  osc_source #(
    .INC(freq_to_inc(HF_HZ)),
    .START_CYC(HF_READY_CYC),
    .LOCK_CYC(HF_LOCK_CYC),
    .STABLE_CYC(HF_STABLE_CYC)
  ) u_high_freq_multiplier_loop (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(hf_en & mf_ready),
    .trim(trim_r),
    .tick(hf_tick),
    .ready(hf_ready),
    .locked(hf_locked),
    .stable(hf_stable)
  );

  osc_source #(
    .INC(freq_to_inc(FSU_HZ)),
    .START_CYC(FSU_START_CYC),
    .LOCK_CYC(FSU_START_CYC),
    .STABLE_CYC(FSU_START_CYC)
  ) u_fast_startup_source (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(fsu_en),
    .trim(TRIM_RST),
    .tick(fsu_tick),
    .ready(fsu_ready),
    .locked(),
    .stable()
  );

  assign status = '{low_freq_ready_flag: lf_ready,
                    mid_freq_ready_flag: mf_ready,
                    high_freq_stable_flag: hf_stable,
                    high_freq_locked_flag: hf_locked,
                    high_freq_ready_flag: hf_ready};

  // -------------------------------------------------------------
  // system clock selection
  // -------------------------------------------------------------
  clk_src_t req_src;
  logic [3:0] req_shift;
  logic [NUM_SRC-1:0] ticks;
  logic [NUM_SRC-1:0] alive;
  logic sys_tick;

  assign req_src = !int_mode ? SRC_EXT
                 : ((sel_src == SRC_HF) & !hf_ready) ? SRC_FSU
                 : sel_src;
  assign req_shift = (req_src == SRC_EXT || req_src == SRC_FSU) ? 4'h0
                   : freq_shift(ctrl_r.internal_freq_select);
  assign ticks = {ext_tick, fsu_tick, hf_tick, mf_tick, lf_tick};
  assign alive = {1'b1, fsu_ready, hf_ready, mf_ready, lf_ready};

  clk_switch u_clk_switch (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(ticks),
    .alive_in(alive),
    .req_src(req_src),
    .req_shift(req_shift),
    .tick_out(sys_tick)
  );

  assign sys_clk_tick = sys_tick;

  // -------------------------------------------------------------
  // instruction clock and pins
  // -------------------------------------------------------------
  logic [1:0] q_cnt_r;
  logic [1:0] q_cnt_nxt;

  assign q_cnt_nxt = sys_tick ? q_cnt_r + 2'h1 : q_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_cnt_r <= 2'h0;
      instr_clk <= 1'b0;
      internal_osc_mode <= 1'b0;
      external_clock_input_pin_released <= 1'b0;
      clock_output_pin_o <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      q_cnt_r <= q_cnt_nxt;
      instr_clk <= q_cnt_nxt[1];
      internal_osc_mode <= int_mode;
      external_clock_input_pin_released <= int_mode;
      clock_output_pin_o <= cfg_clock_output_pin_en ? q_cnt_nxt[1] : gpio_out;
      clock_output_pin_oe <= cfg_clock_output_pin_en | gpio_oe;
    end
  end

endmodule : internal_osc_clock_select

// ### logic/osc_clk_pkg.sv
/*
  shared constants, types and helpers of the internal oscillator and
  clock selection block.
  assumes a single 100 MHz bus clock; every oscillator is modelled as
  a tick stream derived from that clock.
*/
package osc_clk_pkg;

  // -------------------------------------------------------------
  // clock and oscillator rates
  // -------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint MF_HZ = 500_000;
  localparam longint PLL_MULT = 32;
  localparam longint HF_HZ = MF_HZ * PLL_MULT;
  localparam longint LF_HZ = 31_000;
  localparam longint FSU_HZ = 8_000_000;

  // -------------------------------------------------------------
  // start-up and settling times
  // -------------------------------------------------------------
  localparam longint MF_START_NS = 1_000;
  localparam longint LF_START_NS = 1_000;
  localparam longint HF_READY_NS = 2_000;
  localparam longint HF_LOCK_NS = 5_000;
  localparam longint HF_STABLE_NS = 20_000;
  localparam longint FSU_START_NS = 10;

  function automatic int ns_to_cyc(input longint ns);
    longint c;
    c = (ns * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction : ns_to_cyc

  function automatic logic [31:0] freq_to_inc(input longint hz);
    return 32'((hz * 64'h0000_0001_0000_0000) / CLK_HZ);
  endfunction : freq_to_inc

  localparam int MF_START_CYC = ns_to_cyc(MF_START_NS);
  localparam int LF_START_CYC = ns_to_cyc(LF_START_NS);
  localparam int HF_READY_CYC = ns_to_cyc(HF_READY_NS);
  localparam int HF_LOCK_CYC = ns_to_cyc(HF_LOCK_NS);
  localparam int HF_STABLE_CYC = ns_to_cyc(HF_STABLE_NS);
  localparam int FSU_START_CYC = ns_to_cyc(FSU_START_NS);

  // -------------------------------------------------------------
  // register map and fields
  // -------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] TRIM_OFS = 4'h8;
  localparam int TRIM_W = 6;
  localparam int TRIM_SCALE = 8;
  localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;
  localparam logic [1:0] CFG_INTERNAL_OSC_MODE = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] internal_freq_select;
    logic spare_bit;
    logic [1:0] sys_clk_source_select;
  } osc_ctrl_t;

  localparam osc_ctrl_t CTRL_RST = '{internal_freq_select: 4'h7, spare_bit: 1'b0,
                                     sys_clk_source_select: 2'h0};

  typedef struct packed {
    logic low_freq_ready_flag;
    logic mid_freq_ready_flag;
    logic high_freq_stable_flag;
    logic high_freq_locked_flag;
    logic high_freq_ready_flag;
  } osc_status_t;

  // -------------------------------------------------------------
  // clock sources and frequency select decode
  // -------------------------------------------------------------
  typedef enum logic [2:0] {SRC_LF, SRC_MF, SRC_HF, SRC_FSU, SRC_EXT} clk_src_t;
  localparam int NUM_SRC = 5;
  localparam logic [3:0] SEL_MF_LAST = 4'h9;
  localparam logic [3:0] SEL_HF_LAST = 4'hf;

  function automatic clk_src_t freq_src(input logic [3:0] sel);
    if (sel == 4'h0) begin
      return SRC_LF;
    end
    return (sel <= SEL_MF_LAST) ? SRC_MF : SRC_HF;
  endfunction : freq_src

  function automatic logic [3:0] freq_shift(input logic [3:0] sel);
    if (sel == 4'h0) begin
      return 4'h0;
    end
    return (sel <= SEL_MF_LAST) ? 4'(SEL_MF_LAST - sel) : 4'(SEL_HF_LAST - sel);
  endfunction : freq_shift

endpackage : osc_clk_pkg

// ### logic/osc_source.sv
/*
  one oscillator model: phase accumulator tick stream with trim and
  start-up counter that raises ready, locked and stable in turn.
  assumes en and trim come from logic on the same clock.
*/
`timescale 1ns/1ns
module osc_source
  import osc_clk_pkg::*;
#(
  parameter logic [31:0] INC = 32'h0100_0000,
  parameter int START_CYC = 1,
  parameter int LOCK_CYC = 1,
  parameter int STABLE_CYC = 1,
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic signed [TRIM_W-1:0] trim,
  output logic tick,
  output logic ready,
  output logic locked,
  output logic stable
);

  logic [CNT_W-1:0] cnt_r;
  logic [31:0] acc_r;
  logic signed [39:0] inc_s;
  logic signed [39:0] trim_s;
  logic signed [39:0] prod;
  logic [31:0] inc_adj;
  logic [32:0] sum;
  logic cnt_end;

  assign inc_s = 40'(signed'({1'b0, INC}));
  assign trim_s = 40'(trim);
  assign prod = inc_s * trim_s;
  assign inc_adj = 32'(inc_s + (prod >>> TRIM_SCALE));
  assign sum = {1'b0, acc_r} + {1'b0, inc_adj};
  assign cnt_end = (cnt_r == CNT_W'(STABLE_CYC));

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      cnt_r <= '0;
      acc_r <= '0;
      tick <= 1'b0;
      ready <= 1'b0;
      locked <= 1'b0;
      stable <= 1'b0;
    end else begin
      cnt_r <= cnt_end ? cnt_r : cnt_r + 1'b1;
      acc_r <= sum[31:0];
      tick <= sum[32] & ready;
      ready <= (cnt_r >= CNT_W'(START_CYC));
      locked <= (cnt_r >= CNT_W'(LOCK_CYC));
      stable <= (cnt_r >= CNT_W'(STABLE_CYC));
    end
  end

endmodule : osc_source

// ### logic/clk_switch.sv
/*
  source multiplexer and postscaler for the system clock tick.
  assumes one-cycle tick pulses from each source on the same clock.
*/
`timescale 1ns/1ns
module clk_switch
  import osc_clk_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_SRC-1:0] tick_in,
  input wire logic [NUM_SRC-1:0] alive_in,
  input wire clk_src_t req_src,
  input wire logic [3:0] req_shift,
  output logic tick_out
);

  clk_src_t cur_src_r;
  logic [3:0] cur_shift_r;
  logic [CNT_W-1:0] cnt_r;
  logic sel_tick;
  logic at_end;
  logic boundary;

  assign sel_tick = tick_in[cur_src_r];
  assign at_end = (cnt_r == CNT_W'((1 << cur_shift_r) - 1));
  assign boundary = (sel_tick & at_end) | !alive_in[cur_src_r];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_src_r <= SRC_FSU;
      cur_shift_r <= 4'h0;
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= sel_tick & at_end;
      if (boundary) begin
        cur_src_r <= req_src;
        cur_shift_r <= req_shift;
        cnt_r <= '0;
      end else if (sel_tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule : clk_switch

// ### test/osc_sel_chk.sv
/*
  port timing checker of the oscillator and clock select block.
  assumes binding to the top module; straps held steady a few cycles.
*/
`timescale 1ns/1ns
module osc_sel_chk
  import osc_clk_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cfg_osc_select,
  input wire logic cfg_clock_output_pin_enable,
  input wire logic gpio_oe,
  input wire logic internal_osc_mode,
  input wire logic external_clock_input_pin_released,
  input wire logic clock_output_pin_oe
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pin_release: assert property (
    external_clock_input_pin_released == internal_osc_mode)
    else $error("pin release differs from mode");
  chk_strap_mode: assert property (
    (cfg_osc_select == CFG_INTERNAL_OSC_MODE) [*6] |-> internal_osc_mode)
    else $error("strap internal but mode low");
  chk_clock_output_pin_drive: assert property (
    cfg_clock_output_pin_enable [*6] |-> clock_output_pin_oe)
    else $error("clock output pin not driven");
  chk_gpio_follow: assert property (
    (!cfg_clock_output_pin_enable) [*6] ##1 !cfg_clock_output_pin_enable
    |-> clock_output_pin_oe == $past(gpio_oe))
    else $error("pin enable not following port logic");
  chk_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read with data");
  cp_write: cover property (s_axi_bvalid && s_axi_bready);
  cp_read: cover property (s_axi_rvalid && s_axi_rready);
  cp_mode: cover property ($rose(internal_osc_mode));
endmodule : osc_sel_chk

bind internal_osc_clock_select osc_sel_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cfg_osc_select(cfg_osc_select),
  .cfg_clock_output_pin_enable(cfg_clock_output_pin_enable), .gpio_oe(gpio_oe),
  .internal_osc_mode(internal_osc_mode),
  .external_clock_input_pin_released(external_clock_input_pin_released),
  .clock_output_pin_oe(clock_output_pin_oe));

// ### test/internal_osc_clock_select_tb.sv
/*
  self-checking bench of the oscillator and clock select block.
  assumes the block alone, driven over its register bus and straps.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module internal_osc_clock_select_tb;
  import osc_clk_pkg::*;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, tick, iclk, mode, rel, pin_o, pin_oe, cfg_en, ext_pin;
  logic g_out, g_oe, p;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, cfg_sel;
  int num_errors = 0, n_checks = 0, cyc = 0, ticks = 0, e, d, t;
  int codes[5] = '{15, 12, 10, 9, 6};
  internal_osc_clock_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg_osc_select(cfg_sel),
    .cfg_clock_output_pin_enable(cfg_en), .external_clock_input_pin(ext_pin),
    .gpio_out(g_out), .gpio_oe(g_oe), .sys_clk_tick(tick), .instr_clk(iclk),
    .internal_osc_mode(mode), .external_clock_input_pin_released(rel),
    .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe));
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    ticks <= ticks + int'(tick === 1'b1);
    ext_pin <= ~ext_pin;
    if (cyc == 90000) begin
      num_errors++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // bus, measurement and report tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    logic done;
    done = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        done = 1;
        `CHK(bresp, er)
      end
    end
  endtask : wr
  task automatic rdr(input logic [3:0] a, input logic [1:0] er);
    logic done;
    done = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        done = 1;
        rd = rdata;
        `CHK(rresp, er)
      end
    end
  endtask : rdr
  task automatic rc(input logic [3:0] a, input logic [31:0] x);
    rdr(a, AXI_OKAY);
    `CHK(rd, x)
  endtask : rc
  task automatic measure(input int x);
    d = ticks;
    repeat (6400) @(posedge aclk);
    `CHK(ticks - d >= x - 2 && ticks - d <= x + 2, 1'b1)
  endtask : measure
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0dc625e3));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cfg_en, ext_pin, g_out, g_oe} = '0;
    {awaddr, araddr, wstrb, wdata, cfg_sel} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    `CHK(mode, 1'b1)
    `CHK(rel, 1'b1)
    rc(CTRL_OFS, 32'h0000_0038);
    rc(TRIM_OFS, 32'h0000_0000);
    wr(4'hc, 32'hffff_ffff, 4'hf, AXI_SLVERR);
    rdr(4'hc, AXI_SLVERR);
    wr(STAT_OFS, 32'hffff_ffff, 4'hf, AXI_OKAY);
    wr(TRIM_OFS, 32'h0000_001f, 4'h0, AXI_OKAY);
    rc(TRIM_OFS, 32'h0000_0000);
    foreach (codes[i]) begin
      wr(CTRL_OFS, 32'(codes[i]) << 3, 4'hf, AXI_OKAY);
      repeat (3000) @(posedge aclk);
      rc(STAT_OFS, codes[i] > 9 ? 32'h0000_000f : 32'h0000_0008);
      measure(codes[i] > 9 ? 1024 >> (15 - codes[i]) : 32 >> (9 - codes[i]));
    end
    t = $urandom_range(63);
    wr(TRIM_OFS, 32'(t), 4'hf, AXI_OKAY);
    rdr(TRIM_OFS, AXI_OKAY);
    `CHK(rd[5:0], 6'(t))
    wr(CTRL_OFS, 32'h0000_0078, 4'hf, AXI_OKAY);
    repeat (3000) @(posedge aclk);
    measure(1024 * (256 + (t > 31 ? t - 64 : t)) / 256);
    cfg_en <= 1;
    repeat (8) @(posedge aclk);
    `CHK(pin_oe, 1'b1)
    e = 0;
    d = ticks;
    p = pin_o;
    repeat (200) begin
      @(posedge aclk);
      e += int'(pin_o !== p);
      p = pin_o;
      `CHK(pin_o, iclk)
    end
    `CHK(e > 8, 1'b1)
    `CHK(e >= (ticks - d) / 2 - 1 && e <= (ticks - d) / 2 + 1, 1'b1)
    cfg_en <= 0;
    g_out <= 1'($urandom);
    g_oe <= 1'($urandom);
    repeat (8) @(posedge aclk);
    `CHK(pin_oe, g_oe)
    `CHK(pin_o, g_out)
    wr(CTRL_OFS, 32'h0000_0000, 4'hf, AXI_OKAY);
    repeat (300) @(posedge aclk);
    rc(STAT_OFS, 32'h0000_0010);
    cfg_sel <= 2'b11;
    repeat (8) @(posedge aclk);
    `CHK(mode, 1'b0)
    `CHK(rel, 1'b0)
    rc(STAT_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0002, 4'hf, AXI_OKAY);
    repeat (8) @(posedge aclk);
    `CHK(mode, 1'b1)
    aresetn <= 0;
    cfg_sel <= 2'b00;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    repeat (8) @(posedge aclk);
    `CHK(mode, 1'b1)
    rc(CTRL_OFS, 32'h0000_0038);
    final_report();
  end
endmodule : internal_osc_clock_select_tb
